// ===== hdl/swps_pkg.sv
package swps_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] GEN_CTRL_OFS = 8'h00;
    localparam logic [7:0] WAKE_LOW_OFS = 8'h04;
    localparam logic [7:0] WAKE_HIGH_OFS = 8'h08;
    localparam logic [7:0] ASLEEP_WORD_OFS = 8'h0C;
    localparam logic [7:0] RISE1_WORD_OFS = 8'h10;
    localparam logic [7:0] RISE2_WORD_OFS = 8'h14;

    // ****************************************************************
    // general control fields
    // ****************************************************************
    localparam int CTRL_FAST_CLK_BIT = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam int CTRL_PIN_EN_BIT = 2;
    localparam int CTRL_PIN_LVL_BIT = 3;
    localparam int CTRL_TMR_EN_BIT = 4;
    localparam int CTRL_WIDE_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h08;

    // ****************************************************************
    // supply word fields and reset values
    // ****************************************************************
    localparam int DWELL_LSB = 16;
    localparam int TILE_OFF_BIT = 14;
    localparam int ANA_PFM_BIT = 9;
    localparam int CORE_PFM_BIT = 8;
    localparam int IO_EN_BIT = 5;
    localparam int PLL_EN_BIT = 4;
    localparam int ANA_EN_BIT = 1;
    localparam int CORE_EN_BIT = 0;
    localparam logic [31:0] WORD_WR_MASK = 32'h001F4331;
    localparam logic [31:0] ASLEEP_RESET = 32'h00100000;
    localparam logic [31:0] RISE1_RESET = 32'h00100020;
    localparam logic [31:0] RISE2_RESET = 32'h00100031;
    localparam logic [31:0] RUN_WORD = 32'h00000033;
    localparam logic [31:0] FALL1_WORD = 32'h00000022;
    localparam logic [31:0] FALL2_WORD = 32'h00000002;
    localparam logic [4:0] FALL_DWELL_LOG2 = 5'h10;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 250000000;
    localparam int SLOW_CLK_HZ = 31250;
    localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_CLK_HZ;

    typedef enum logic [2:0] {
        ST_RUNNING,
        ST_FIRST_FALLING,
        ST_SECOND_FALLING,
        ST_ASLEEP,
        ST_FIRST_RISING,
        ST_SECOND_RISING
    } swps_state_e;

    typedef struct packed {
        logic tile_clk_off;
        logic analogue_pfm;
        logic core_pfm;
        logic io_en;
        logic pll_en;
        logic analogue_en;
        logic core_en;
    } swps_supply_s;

endpackage : swps_pkg

// ===== hdl/swps_sequencer.sv
`timescale 1ns/100ps
// Behaviour
// - low wake time matters only with timer wake enabled and while asleep
// - high wake time compared only if wide compare, timer wake, asleep
// - asleep: after dwell, wake on timer or wake pin condition
// - dwell counted on the active clock, possibly the slow one
// - rising states: after dwell, advance only when enabled supplies good
// - dwell field 20:16 gives two to that power cycles, reset 16
// - bit 14 gates the tile clock during the state
// - bit 9 picks analogue regulator modulation, one means pulse frequency
// - bit 8 picks core regulator modulation, one means pulse frequency
// - bit 5 enables io supply; reset zero asleep, one rising
// - bit 4 enables pll regulator; reset one only second rising
// - bit 1 analogue enable is read only: 0,0,1 per state
// - bit 0 enables core regulator; reset one only second rising
// - low wake time: 32-bit read write, resets zero
// - high wake time: 32-bit read write, resets zero, ignored unless wide
// - control bit 5 enables wide 64-bit compare
// - control bit 4 enables timer wake
// - control bit 2 enables pin wake, bit 3 picks level
// - control bit 1 starts sleep when running and clears itself
module swps_sequencer #(
    parameter int SLOW_DIV = swps_pkg::SLOW_DIV_CYC,
    parameter logic [4:0] FALL_DWELL = swps_pkg::FALL_DWELL_LOG2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_q,
    // time base
    input wire logic [63:0] rtc_count,
    // pins
    input wire logic wake_pin,
    input wire logic core_good,
    input wire logic analogue_good,
    input wire logic pll_good,
    input wire logic io_good,
    // supply control
    output swps_pkg::swps_supply_s supply_q,
    output swps_pkg::swps_state_e state_q
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end else begin
            pin_meta_q <= {wake_pin, io_good, pll_good, analogue_good, core_good};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [5:0] ctrl_q;
    logic [31:0] wake_lo_q;
    logic [31:0] wake_hi_q;
    logic [31:0] word_q [3];
    logic sleep_take;
    swps_pkg::swps_state_e state_d;

    localparam logic [31:0] WORD_RST [3] = '{swps_pkg::ASLEEP_RESET,
        swps_pkg::RISE1_RESET, swps_pkg::RISE2_RESET};
    localparam logic [7:0] WORD_OFS [3] = '{swps_pkg::ASLEEP_WORD_OFS,
        swps_pkg::RISE1_WORD_OFS, swps_pkg::RISE2_WORD_OFS};

    assign sleep_take = (state_q == swps_pkg::ST_RUNNING) && ctrl_q[swps_pkg::CTRL_SLEEP_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= swps_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == swps_pkg::GEN_CTRL_OFS) begin
            ctrl_q[5:2] <= reg_wdata[5:2];
            ctrl_q[swps_pkg::CTRL_FAST_CLK_BIT] <= reg_wdata[swps_pkg::CTRL_FAST_CLK_BIT];
            // a set landing with the take wins; sets outside running are dropped
            ctrl_q[swps_pkg::CTRL_SLEEP_BIT] <= reg_wdata[swps_pkg::CTRL_SLEEP_BIT]
                && state_q == swps_pkg::ST_RUNNING;
        end else if (sleep_take) begin
            ctrl_q[swps_pkg::CTRL_SLEEP_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_lo_q <= 32'h00000000;
            wake_hi_q <= 32'h00000000;
        end else if (reg_wr) begin
            if (reg_addr == swps_pkg::WAKE_LOW_OFS) begin
                wake_lo_q <= reg_wdata;
            end
            if (reg_addr == swps_pkg::WAKE_HIGH_OFS) begin
                wake_hi_q <= reg_wdata;
            end
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_word
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                word_q[i] <= WORD_RST[i];
            end else if (reg_wr && reg_addr == WORD_OFS[i]) begin
                word_q[i] <= reg_wdata & swps_pkg::WORD_WR_MASK;
            end
        end
    end

    // analogue enable is fixed per state, never stored
    function automatic logic [31:0] ro_bits(input int idx);
        ro_bits = (idx == 2) ? 32'h00000002 : 32'h00000000;
    endfunction : ro_bits

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                swps_pkg::GEN_CTRL_OFS: reg_rdata_q <= {26'h0000000, ctrl_q};
                swps_pkg::WAKE_LOW_OFS: reg_rdata_q <= wake_lo_q;
                swps_pkg::WAKE_HIGH_OFS: reg_rdata_q <= wake_hi_q;
                swps_pkg::ASLEEP_WORD_OFS: reg_rdata_q <= word_q[0] | ro_bits(0);
                swps_pkg::RISE1_WORD_OFS: reg_rdata_q <= word_q[1] | ro_bits(1);
                swps_pkg::RISE2_WORD_OFS: reg_rdata_q <= word_q[2] | ro_bits(2);
                default: reg_rdata_q <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // wake conditions
    // ****************************************************************
    logic asleep;
    logic timer_hit;
    logic pin_hit;

    assign asleep = state_q == swps_pkg::ST_ASLEEP;
    assign timer_hit = asleep && ctrl_q[swps_pkg::CTRL_TMR_EN_BIT]
        && (ctrl_q[swps_pkg::CTRL_WIDE_BIT] ? rtc_count >= {wake_hi_q, wake_lo_q}
                                            : rtc_count[31:0] >= wake_lo_q);
    assign pin_hit = asleep && ctrl_q[swps_pkg::CTRL_PIN_EN_BIT]
        && (pin_sync_q[4] == ctrl_q[swps_pkg::CTRL_PIN_LVL_BIT]);

    // ****************************************************************
    // dwell timing
    // ****************************************************************
    logic [15:0] div_q;
    logic slow_tick_q;
    logic tick;
    logic [31:0] dwell_cnt_q;
    logic [31:0] dwell_len;
    logic [31:0] cur_word;
    logic [4:0] dwell_log2;
    logic dwell_done;

    // slow clock stands in as an enable so the block keeps one clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 16'h0000;
            slow_tick_q <= 1'b0;
        end else begin
            slow_tick_q <= div_q == 16'(SLOW_DIV - 1);
            div_q <= (div_q == 16'(SLOW_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // clock select only matters while asleep
    assign tick = !asleep || ctrl_q[swps_pkg::CTRL_FAST_CLK_BIT] || slow_tick_q;

    always_comb begin
        unique case (state_q)
            swps_pkg::ST_RUNNING: cur_word = swps_pkg::RUN_WORD;
            swps_pkg::ST_FIRST_FALLING: cur_word = swps_pkg::FALL1_WORD;
            swps_pkg::ST_SECOND_FALLING: cur_word = swps_pkg::FALL2_WORD;
            swps_pkg::ST_ASLEEP: cur_word = word_q[0] | ro_bits(0);
            swps_pkg::ST_FIRST_RISING: cur_word = word_q[1] | ro_bits(1);
            default: cur_word = word_q[2] | ro_bits(2);
        endcase
    end

    assign dwell_log2 = (state_q == swps_pkg::ST_FIRST_FALLING
        || state_q == swps_pkg::ST_SECOND_FALLING) ? FALL_DWELL
        : cur_word[swps_pkg::DWELL_LSB +: 5];
    assign dwell_len = 32'h00000001 << dwell_log2;
    assign dwell_done = dwell_cnt_q >= dwell_len;

    always_ff @(posedge clk) begin
        if (!rst_n || state_d != state_q) begin
            dwell_cnt_q <= 32'h00000000;
        end else if (tick && !dwell_done) begin
            dwell_cnt_q <= dwell_cnt_q + 32'h00000001;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic all_good;

    // a supply that is switched off cannot hold back the sequence
    assign all_good = &(~{cur_word[swps_pkg::IO_EN_BIT], cur_word[swps_pkg::PLL_EN_BIT],
        cur_word[swps_pkg::ANA_EN_BIT], cur_word[swps_pkg::CORE_EN_BIT]}
        | pin_sync_q[3:0]);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            swps_pkg::ST_RUNNING: if (sleep_take) state_d = swps_pkg::ST_FIRST_FALLING;
            swps_pkg::ST_FIRST_FALLING: if (dwell_done) state_d = swps_pkg::ST_SECOND_FALLING;
            swps_pkg::ST_SECOND_FALLING: if (dwell_done) state_d = swps_pkg::ST_ASLEEP;
            swps_pkg::ST_ASLEEP: begin
                if (dwell_done && (timer_hit || pin_hit)) begin
                    state_d = swps_pkg::ST_FIRST_RISING;
                end
            end
            swps_pkg::ST_FIRST_RISING: begin
                if (dwell_done && all_good) state_d = swps_pkg::ST_SECOND_RISING;
            end
            swps_pkg::ST_SECOND_RISING: begin
                if (dwell_done && all_good) state_d = swps_pkg::ST_RUNNING;
            end
            default: state_d = swps_pkg::ST_RUNNING;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= swps_pkg::ST_RUNNING;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs follow the word of the state being held or entered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            supply_q <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            unique case (state_d)
                swps_pkg::ST_RUNNING: supply_q <= word_to_supply(swps_pkg::RUN_WORD);
                swps_pkg::ST_FIRST_FALLING: supply_q <= word_to_supply(swps_pkg::FALL1_WORD);
                swps_pkg::ST_SECOND_FALLING: supply_q <= word_to_supply(swps_pkg::FALL2_WORD);
                swps_pkg::ST_ASLEEP: supply_q <= word_to_supply(word_q[0] | ro_bits(0));
                swps_pkg::ST_FIRST_RISING: supply_q <= word_to_supply(word_q[1] | ro_bits(1));
                default: supply_q <= word_to_supply(word_q[2] | ro_bits(2));
            endcase
        end
    end

    function automatic swps_pkg::swps_supply_s word_to_supply(input logic [31:0] w);
        word_to_supply.tile_clk_off = w[swps_pkg::TILE_OFF_BIT];
        word_to_supply.analogue_pfm = w[swps_pkg::ANA_PFM_BIT];
        word_to_supply.core_pfm = w[swps_pkg::CORE_PFM_BIT];
        word_to_supply.io_en = w[swps_pkg::IO_EN_BIT];
        word_to_supply.pll_en = w[swps_pkg::PLL_EN_BIT];
        word_to_supply.analogue_en = w[swps_pkg::ANA_EN_BIT];
        word_to_supply.core_en = w[swps_pkg::CORE_EN_BIT];
    endfunction : word_to_supply

    // ****************************************************************
    // checks
    // ****************************************************************
    timer_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        asleep && state_d == swps_pkg::ST_FIRST_RISING && !pin_hit
        |-> ctrl_q[swps_pkg::CTRL_TMR_EN_BIT])
        else $error("timer wake while timer wake disabled");

    narrow_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
        asleep && dwell_done && ctrl_q[swps_pkg::CTRL_TMR_EN_BIT]
        && !ctrl_q[swps_pkg::CTRL_WIDE_BIT] && rtc_count[31:0] >= wake_lo_q
        |-> state_d == swps_pkg::ST_FIRST_RISING)
        else $error("narrow compare looked at high word");

    asleep_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
        asleep && state_d == swps_pkg::ST_FIRST_RISING |-> dwell_done && (timer_hit || pin_hit))
        else $error("left asleep without dwell or wake");

    slow_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        asleep && state_d == swps_pkg::ST_ASLEEP && !tick |=> $stable(dwell_cnt_q))
        else $error("dwell counted without an active clock edge");

    rise_good_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == swps_pkg::ST_FIRST_RISING ##1 state_q == swps_pkg::ST_SECOND_RISING
        |-> $past(all_good) && $past(dwell_done))
        else $error("rose with a supply not good");

    dwell_min_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_q != swps_pkg::ST_RUNNING && state_d != state_q |-> dwell_cnt_q >= dwell_len)
        else $error("state left before its dwell");

    supply_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == swps_pkg::ST_ASLEEP ##1 state_q == swps_pkg::ST_ASLEEP
        |-> supply_q.tile_clk_off == $past(word_q[0][swps_pkg::TILE_OFF_BIT])
            && supply_q.core_en == $past(word_q[0][swps_pkg::CORE_EN_BIT]))
        else $error("asleep word not driven");

    sleep_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_take && !reg_wr |=> !ctrl_q[swps_pkg::CTRL_SLEEP_BIT]
            && state_q == swps_pkg::ST_FIRST_FALLING)
        else $error("sleep request not taken and cleared");

    order_a: assert property (@(posedge clk) disable iff (!rst_n)
        asleep |=> state_q == swps_pkg::ST_ASLEEP || state_q == swps_pkg::ST_FIRST_RISING)
        else $error("asleep left in wrong order");

endmodule : swps_sequencer

// ===== tb/swps_supply_model.sv
`timescale 1ns/100ps
module swps_supply_model #(
    parameter int DLY = 3
) (
    // clock
    input wire logic clk,
    // bench control
    input wire logic stall,
    input wire logic wake_req,
    // supply enables from the sequencer
    input wire swps_pkg::swps_supply_s supply,
    // pins back to the sequencer
    output logic wake_pin,
    output logic core_good,
    output logic analogue_good,
    output logic pll_good,
    output logic io_good
);
    logic [3:0] en;
    logic [3:0] good;
    int cnt [4];

    assign en = {supply.io_en, supply.pll_en, supply.analogue_en, supply.core_en};
    assign wake_pin = wake_req;

    // a regulator needs DLY cycles to come up; stall holds all of them down
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!en[i] || stall) begin
                cnt[i] <= 0;
            end else if (cnt[i] < DLY) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            good[i] = (cnt[i] >= DLY);
        end
    end

    assign {io_good, pll_good, analogue_good, core_good} = good;
endmodule : swps_supply_model

// ===== tb/test_sleep_wake_power_sequencer.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_sleep_wake_power_sequencer;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] rdata;
    logic [63:0] rtc = 64'h0;
    logic stall = 1'b0;
    logic wake_req = 1'b1;
    logic wake_pin, core_good, analogue_good, pll_good, io_good;
    swps_pkg::swps_supply_s supply;
    swps_pkg::swps_state_e state;
    int err_count = 0;
    int cmp_count = 0;
    int n;

    always #2 clk = ~clk;

    swps_sequencer #(.SLOW_DIV(4), .FALL_DWELL(5'h00)) u_dut (
        .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .rtc_count(rtc), .wake_pin(wake_pin),
        .core_good(core_good), .analogue_good(analogue_good), .pll_good(pll_good),
        .io_good(io_good), .supply_q(supply), .state_q(state));

    swps_supply_model #(.DLY(3)) u_model (
        .clk(clk), .stall(stall), .wake_req(wake_req), .supply(supply),
        .wake_pin(wake_pin), .core_good(core_good), .analogue_good(analogue_good),
        .pll_good(pll_good), .io_good(io_good));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk); #1;
        reg_wr = 1'b0;
        // one idle edge so a following call never re-raises the strobe in this step
        @(posedge clk); #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk); #1;
        reg_rd = 1'b0;
        `CHK(rdata, e)
        @(posedge clk); #1;
    endtask : rd

    // bounded wait for a state, then check the supply word applied on entry
    task automatic wait_st(input swps_pkg::swps_state_e s, input logic [6:0] sup);
        n = 0;
        while (state !== s && n < 2000) begin
            @(posedge clk); #1;
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("wait limit at %0t for state %0d", $time, s);
            wrap_up();
        end else begin
            `CHK(supply, sup)
        end
    endtask : wait_st

    // falling states carry fixed words; sleep bit only honoured while running
    task automatic go_sleep(input logic [31:0] ctrl, input logic [6:0] asleep_sup);
        wr(swps_pkg::GEN_CTRL_OFS, ctrl | 32'h00000002);
        wait_st(swps_pkg::ST_FIRST_FALLING, 7'h0A);
        wait_st(swps_pkg::ST_SECOND_FALLING, 7'h02);
        wait_st(swps_pkg::ST_ASLEEP, asleep_sup);
    endtask : go_sleep

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic reset_values();
        `CHK(state, swps_pkg::ST_RUNNING)
        `CHK(supply, 7'h0F)
        rd(swps_pkg::GEN_CTRL_OFS, 32'h00000008);
        rd(swps_pkg::WAKE_LOW_OFS, 32'h00000000);
        rd(swps_pkg::WAKE_HIGH_OFS, 32'h00000000);
        rd(swps_pkg::ASLEEP_WORD_OFS, 32'h00100000);
        rd(swps_pkg::RISE1_WORD_OFS, 32'h00100020);
        rd(swps_pkg::RISE2_WORD_OFS, 32'h00100033);
        rd(8'h18, 32'h00000000);
    endtask : reset_values

    task automatic reg_access();
        wr(swps_pkg::WAKE_LOW_OFS, 32'hA5A55A5A);
        rd(swps_pkg::WAKE_LOW_OFS, 32'hA5A55A5A);
        wr(swps_pkg::WAKE_HIGH_OFS, 32'h12345678);
        rd(swps_pkg::WAKE_HIGH_OFS, 32'h12345678);
        wr(swps_pkg::ASLEEP_WORD_OFS, 32'hFFFFFFFF);
        rd(swps_pkg::ASLEEP_WORD_OFS, 32'h001F4331);
        wr(swps_pkg::RISE2_WORD_OFS, 32'h00000000);
        rd(swps_pkg::RISE2_WORD_OFS, 32'h00000002);
    endtask : reg_access

    // narrow compare; high word holds junk that a wide compare would trip on
    task automatic timer_wake();
        wr(swps_pkg::WAKE_LOW_OFS, 32'h00000100);
        wr(swps_pkg::ASLEEP_WORD_OFS, 32'h00004300);
        wr(swps_pkg::RISE1_WORD_OFS, 32'h00000021);
        wr(swps_pkg::RISE2_WORD_OFS, 32'h00000031);
        rtc = 64'h50;
        go_sleep(32'h00000011, 7'h70);
        repeat (30) @(posedge clk);
        #1;
        `CHK(state, swps_pkg::ST_ASLEEP)
        rtc = 64'h100;
        wait_st(swps_pkg::ST_FIRST_RISING, 7'h09);
        wait_st(swps_pkg::ST_SECOND_RISING, 7'h0F);
        wait_st(swps_pkg::ST_RUNNING, 7'h0F);
        rd(swps_pkg::GEN_CTRL_OFS, 32'h00000011);
    endtask : timer_wake

    // pin enabled for high level but held low: only the wide timer may wake
    task automatic wide_wake();
        wr(swps_pkg::WAKE_HIGH_OFS, 32'h00000001);
        wr(swps_pkg::WAKE_LOW_OFS, 32'h00000000);
        wr(swps_pkg::ASLEEP_WORD_OFS, 32'h00000200);
        rtc = 64'h00000000FFFFFFFF;
        wake_req = 1'b0;
        go_sleep(32'h0000003D, 7'h20);
        repeat (30) @(posedge clk);
        #1;
        `CHK(state, swps_pkg::ST_ASLEEP)
        rtc = 64'h0000000100000000;
        wait_st(swps_pkg::ST_FIRST_RISING, 7'h09);
        wait_st(swps_pkg::ST_RUNNING, 7'h0F);
    endtask : wide_wake

    // slow clock dwell of 8 ticks, low-level pin, supplies held bad meanwhile
    task automatic pin_slow_wake();
        wr(swps_pkg::ASLEEP_WORD_OFS, 32'h00030000);
        rtc = 64'h0;
        stall = 1'b1;
        wake_req = 1'b0;
        go_sleep(32'h00000004, 7'h00);
        wait_st(swps_pkg::ST_FIRST_RISING, 7'h09);
        `CHK((n >= 28) && (n <= 40), 1'b1)
        wr(swps_pkg::GEN_CTRL_OFS, 32'h00000006);
        rd(swps_pkg::GEN_CTRL_OFS, 32'h00000004);
        repeat (20) @(posedge clk);
        #1;
        `CHK(state, swps_pkg::ST_FIRST_RISING)
        stall = 1'b0;
        wake_req = 1'b1;
        wait_st(swps_pkg::ST_SECOND_RISING, 7'h0F);
        wait_st(swps_pkg::ST_RUNNING, 7'h0F);
    endtask : pin_slow_wake

    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        reset_values();
        reg_access();
        timer_wake();
        wide_wake();
        pin_slow_wake();
        wrap_up();
    end
endmodule : test_sleep_wake_power_sequencer
